// file: hw/dio_dev_end.sv
`timescale 1ns/1ps
`default_nettype none
module dio_dev_end
  import dio_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  dio_if.dev bus,
  input wire logic [DIO_LINES-1:0] line_i,
  output logic [DIO_LINES-1:0] line_o,
  output logic [DIO_LINES-1:0] line_oe,
  input wire logic dbuf_clk,
  output logic [DIO_CTL_W-1:0] sync_ctrl
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [DIO_LINES-1:0] latch_r, latch_nxt;
  logic [DIO_LINES-1:0] drive_r, drive_nxt;
  logic [DIO_LINES-1:0] in_s1_r, in_s2_r;
  logic [DIO_LINES-1:0] sense_r;
  logic [DIO_CTL_W-1:0] ctrl_r, ctrl_nxt;
  logic clk_s1_r, clk_s2_r, src_d_r;
  logic ack_r;
  logic [DIO_DW-1:0] rdata_r;

  // decode results
  logic [2:0] lat_we;
  logic ctl_we;
  logic [DIO_LINES-1:0] wd24;
  logic [DIO_CTL_W-1:0] wctl;
  logic [DIO_DW-1:0] rd_val;
  logic [7:0] rb;
  logic [1:0] kind;
  logic [1:0] idx;

  localparam logic [1:0] K_NONE = 2'd0;
  localparam logic [1:0] K_LAT = 2'd1;
  localparam logic [1:0] K_PIN = 2'd2;
  localparam logic [1:0] K_CTL = 2'd3;

  // ----------------------------------------
  // address normalisation and lanes
  // ----------------------------------------
  wire is_byte = bus.is_byte;
  wire is_isa = bus.map == DIO_MAP_ISA;
  // nubus bytes are folded back onto the vme map; words are untouched
  wire [3:0] eff_a = (is_byte && bus.map == DIO_MAP_NUBUS) ?
    dio_nubus_to_vme(bus.addr) : bus.addr[3:0];
  wire addr_hi_zero = (is_byte && bus.map == DIO_MAP_NUBUS) || (bus.addr[5:4] == 2'b00);
  // only vme uses the upper lane, and only for even byte addresses
  wire lane_hi = is_byte && (bus.map == DIO_MAP_VME) && !eff_a[0];
  wire [7:0] bdat = lane_hi ? bus.wdata[15:8] : bus.wdata[7:0];
  wire wr = bus.req && bus.we;

  // ----------------------------------------
  // byte map: kind of target and byte group
  // ----------------------------------------
  always_comb begin
    kind = K_NONE;
    idx = 2'd0;
    if (!addr_hi_zero) begin
      kind = K_NONE;
    end else if (is_isa) begin
      if (eff_a == DIO_IB_LAT_A) begin
        kind = K_LAT;
        idx = 2'd0;
      end else if (eff_a == DIO_IB_LAT_B) begin
        kind = K_LAT;
        idx = 2'd1;
      end else if (eff_a == DIO_IB_LAT_C) begin
        kind = K_LAT;
        idx = 2'd2;
      end else if (eff_a == DIO_IB_PIN_A) begin
        kind = K_PIN;
        idx = 2'd0;
      end else if (eff_a == DIO_IB_PIN_B) begin
        kind = K_PIN;
        idx = 2'd1;
      end else if (eff_a == DIO_IB_PIN_C) begin
        kind = K_PIN;
        idx = 2'd2;
      end else if (eff_a == DIO_IB_CTRL) begin
        kind = K_CTL;
      end
    end else begin
      if (eff_a == DIO_VB_LAT_A) begin
        kind = K_LAT;
        idx = 2'd0;
      end else if (eff_a == DIO_VB_LAT_B) begin
        kind = K_LAT;
        idx = 2'd1;
      end else if (eff_a == DIO_VB_LAT_C) begin
        kind = K_LAT;
        idx = 2'd2;
      end else if (eff_a == DIO_VB_PIN_A) begin
        kind = K_PIN;
        idx = 2'd0;
      end else if (eff_a == DIO_VB_PIN_B) begin
        kind = K_PIN;
        idx = 2'd1;
      end else if (eff_a == DIO_VB_PIN_C) begin
        kind = K_PIN;
        idx = 2'd2;
      end else if (eff_a == DIO_VB_CTRL) begin
        kind = K_CTL;
      end
    end
  end

  // ----------------------------------------
  // word and byte access decode
  // ----------------------------------------
  // long words arrive as two word cycles, so the word map also covers
  // long layout: 0x0 then 0x2, and 0xC carrying bits 19:16 first
  always_comb begin
    lat_we = 3'b000;
    ctl_we = 1'b0;
    wd24 = '0;
    wctl = bus.wdata[DIO_CTL_W-1:0];
    rd_val = 16'h0000;
    rb = 8'h00;
    if (!is_byte) begin
      if (!addr_hi_zero) begin
        rd_val = 16'h0000;
      end else if (eff_a == DIO_OFS_LAT_LO) begin
        lat_we = 3'b011;
        wd24 = {8'h00, bus.wdata};
        rd_val = latch_r[15:0];
      end else if (eff_a == DIO_OFS_LAT_HI) begin
        lat_we = 3'b100;
        wd24 = {bus.wdata[7:0], 16'h0000};
        rd_val = {8'h00, latch_r[23:16]};
      end else if (eff_a == DIO_OFS_PIN_LO) begin
        rd_val = sense_r[15:0];
      end else if (eff_a == DIO_OFS_PIN_HI) begin
        rd_val = {8'h00, sense_r[23:16]};
      end else if (eff_a == DIO_OFS_CTRL) begin
        ctl_we = 1'b1;
        rd_val = {12'h000, ctrl_r};
      end
    end else begin
      wctl = bdat[DIO_CTL_W-1:0];
      wd24 = {bdat, bdat, bdat};
      case (kind)
        K_LAT: begin
          lat_we[idx] = 1'b1;
          rb = latch_r[idx*8 +: 8];
        end
        K_PIN: begin
          rb = sense_r[idx*8 +: 8];
        end
        K_CTL: begin
          ctl_we = 1'b1;
          rb = {4'h0, ctrl_r};
        end
        default: begin
          rb = 8'h00;
        end
      endcase
      rd_val = lane_hi ? {rb, 8'h00} : {8'h00, rb};
    end
  end

  // ----------------------------------------
  // next latch and control values
  // ----------------------------------------
  // reads never touch state, so read-modify-write stays exact
  always_comb begin
    latch_nxt = latch_r;
    ctrl_nxt = ctrl_r;
    for (int k = 0; k < 3; k++) begin
      if (wr && lat_we[k]) begin
        latch_nxt[k*8 +: 8] = wd24[k*8 +: 8];
      end
    end
    if (wr && ctl_we) begin
      ctrl_nxt = wctl;
    end
  end

  // ----------------------------------------
  // double buffer clock
  // ----------------------------------------
  // pin clock of at most 1 MHz is oversampled, so an edge is never missed
  wire ms_en = ctrl_r[DIO_CTL_MS_EN];
  wire src_clk = ms_en ? in_s2_r[DIO_SLAVE_LINE] : clk_s2_r;
  wire db_edge = ctrl_r[DIO_CTL_POL] ? (src_d_r && !src_clk) :
    (!src_d_r && src_clk);
  wire db_en = ctrl_r[DIO_CTL_DBUF_EN];
  wire take = !db_en || db_edge;

  // drive low wherever the latch holds zero; master re-drives the clock
  always_comb begin
    drive_nxt = take ? ~latch_r : drive_r;
    if (ms_en && ctrl_r[DIO_CTL_MASTER]) begin
      drive_nxt[DIO_MASTER_LINE] = !clk_s2_r;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // pins and the external clock cross into mclk through two flops
  always_ff @(posedge mclk) begin
    in_s1_r <= line_i;
    in_s2_r <= in_s1_r;
    clk_s1_r <= dbuf_clk;
    clk_s2_r <= clk_s1_r;
    src_d_r <= src_clk;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      latch_r <= DIO_LATCH_RST;
      ctrl_r <= DIO_CTRL_RST;
      drive_r <= '0;
      sense_r <= DIO_SENSE_RST;
    end else begin
      latch_r <= latch_nxt;
      ctrl_r <= ctrl_nxt;
      drive_r <= drive_nxt;
      if (take) begin
        sense_r <= in_s2_r;
      end
    end
  end

  // one-cycle answer to every request, mapped or not
  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      ack_r <= bus.req;
      rdata_r <= (bus.req && !bus.we) ? rd_val : 16'h0000;
    end
  end

  // open-collector pins: value is always low, enable does the work
  assign line_o = '0;
  assign line_oe = drive_r;
  assign sync_ctrl = ctrl_r;
  assign bus.ack = ack_r;
  assign bus.rdata = rdata_r;
endmodule
`default_nettype wire

// file: hw/dio_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module dio_host_end
  import dio_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  dio_if.host bus,
  input wire dio_map_t map_mode,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire dio_size_t cmd_size,
  input wire logic [3:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata
);
  typedef enum logic {H_IDLE, H_WAIT} dio_hst_t;

  dio_hst_t st_r;
  logic ready_r, rsp_r, req_r, we_r, byte_r, second_r, long_r, lane_hi_r;
  logic [31:0] rsp_data_r, long_data_r;
  logic [15:0] hi_half_r, bwdata_r;
  logic [5:0] baddr_r;
  logic [3:0] long_addr_r;
  dio_map_t map_r;

  // ----------------------------------------
  // first bus cycle of a command
  // ----------------------------------------
  wire accept = (st_r == H_IDLE) && ready_r && cmd_valid;
  wire is_long = cmd_size == DIO_SZ_LONG;
  wire is_b = cmd_size == DIO_SZ_BYTE;
  // vme places even bytes on the upper lane, others always use d7..d0
  wire lane_hi = is_b && (map_mode == DIO_MAP_VME) && !cmd_addr[0];
  wire [5:0] first_addr = (is_b && map_mode == DIO_MAP_NUBUS) ?
    dio_vme_to_nubus(cmd_addr) : {2'b00, cmd_addr};
  wire [15:0] first_data = is_long ? cmd_wdata[31:16] :
    (lane_hi ? {cmd_wdata[7:0], 8'h00} : (is_b ? {8'h00, cmd_wdata[7:0]} :
    cmd_wdata[15:0]));
  wire [7:0] rd_byte = lane_hi_r ? bus.rdata[15:8] : bus.rdata[7:0];
  wire split_next = (st_r == H_WAIT) && bus.ack && long_r && !second_r;
  wire done = (st_r == H_WAIT) && bus.ack && !split_next;

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= H_IDLE;
      ready_r <= 1'b0;
      rsp_r <= 1'b0;
      req_r <= 1'b0;
      second_r <= 1'b0;
    end else begin
      rsp_r <= done;
      req_r <= accept || split_next;
      case (st_r)
        H_IDLE: begin
          ready_r <= !accept;
          if (accept) begin
            st_r <= H_WAIT;
            second_r <= 1'b0;
          end
        end
        H_WAIT: begin
          if (split_next) begin
            second_r <= 1'b1;
          end
          if (done) begin
            st_r <= H_IDLE;
            ready_r <= 1'b1;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  // command fields; second long half goes to the next word, low 16 bits
  always_ff @(posedge mclk) begin
    map_r <= map_mode;
    if (accept) begin
      we_r <= cmd_write;
      byte_r <= is_b;
      long_r <= is_long;
      lane_hi_r <= lane_hi;
      baddr_r <= first_addr;
      bwdata_r <= first_data;
      long_addr_r <= cmd_addr + DIO_OFS_LONG_HALF;
      long_data_r <= cmd_wdata;
    end else if (split_next) begin
      baddr_r <= {2'b00, long_addr_r};
      bwdata_r <= long_data_r[15:0];
      hi_half_r <= bus.rdata;
    end
  end

  // reply assembly
  always_ff @(posedge mclk) begin
    if (reset) begin
      rsp_data_r <= 32'h0000_0000;
    end else if (done) begin
      if (long_r) begin
        rsp_data_r <= {hi_half_r, bus.rdata};
      end else if (byte_r) begin
        rsp_data_r <= {24'h00_0000, rd_byte};
      end else begin
        rsp_data_r <= {16'h0000, bus.rdata};
      end
    end
  end

  assign bus.req = req_r;
  assign bus.we = we_r;
  assign bus.is_byte = byte_r;
  assign bus.addr = baddr_r;
  assign bus.wdata = bwdata_r;
  assign bus.map = map_r;
  assign cmd_ready = ready_r;
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rsp_data_r;
endmodule
`default_nettype wire

// file: hw/dio_if.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// 16-bit carrier port between host and module
// ----------------------------------------
interface dio_if;
  import dio_pkg::*;
  logic req;
  logic we;
  logic is_byte;
  logic [DIO_AW-1:0] addr;
  logic [DIO_DW-1:0] wdata;
  dio_map_t map;
  logic [DIO_DW-1:0] rdata;
  logic ack;
  modport dev (input req, input we, input is_byte, input addr, input wdata, input map,
    output rdata, output ack);
  modport host (output req, output we, output is_byte, output addr, output wdata,
    output map, input rdata, input ack);
endinterface
`default_nettype wire

// file: hw/dio_pkg.sv
// Summary of operation
// - word write 0x0 loads lines 1-16
// - word write 0x2 loads lines 17-24
// - high group bits 15:8 dropped, read zero
// - words 0x0/0x2 read back latches
// - words 0x4/0x6 read pin levels
// - word 0xC holds four control bits
// - vme bytes 0x1/0x0/0x3 reach latches
// - vme bytes 0x5/0x4/0x7 read pins
// - byte control at 0xD vme, 0xC isa
// - long write 0x0 updates all 24 latches
// - long reads return latches or pins
// - long control bits sit at 19:16
// - host splits long into two words
// - nubus byte address is twice vme minus one
// - nubus bytes travel on d7..d0
// - nubus words keep vme address, d15..d0
// - isa bytes 0x0/0x1/0x2 reach latches
// - isa bytes 0x4/0x5/0x6 read pins
// - control bit 0 enables double buffering
// - control bit 1 picks falling clock edge
// - reset sets latches to one, clears control
// - latch one floats line, zero pulls low
package dio_pkg;
  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int DIO_LINES = 24;
  localparam int DIO_AW = 6;
  localparam int DIO_DW = 16;
  localparam logic [23:0] DIO_LATCH_RST = 24'hFF_FFFF;
  localparam logic [23:0] DIO_SENSE_RST = 24'hFF_FFFF;
  localparam logic [3:0] DIO_CTRL_RST = 4'h0;
  localparam int DIO_MASTER_LINE = 22;
  localparam int DIO_SLAVE_LINE = 23;
  // ----------------------------------------
  // word offsets, same in every map
  // ----------------------------------------
  localparam logic [3:0] DIO_OFS_LAT_LO = 4'h0;
  localparam logic [3:0] DIO_OFS_LAT_HI = 4'h2;
  localparam logic [3:0] DIO_OFS_PIN_LO = 4'h4;
  localparam logic [3:0] DIO_OFS_PIN_HI = 4'h6;
  localparam logic [3:0] DIO_OFS_CTRL = 4'hC;
  localparam logic [3:0] DIO_OFS_LONG_HALF = 4'h2;
  // ----------------------------------------
  // byte offsets; groups a=1-8, b=9-16, c=17-24
  // ----------------------------------------
  localparam logic [3:0] DIO_VB_LAT_A = 4'h1;
  localparam logic [3:0] DIO_VB_LAT_B = 4'h0;
  localparam logic [3:0] DIO_VB_LAT_C = 4'h3;
  localparam logic [3:0] DIO_VB_PIN_A = 4'h5;
  localparam logic [3:0] DIO_VB_PIN_B = 4'h4;
  localparam logic [3:0] DIO_VB_PIN_C = 4'h7;
  localparam logic [3:0] DIO_VB_CTRL = 4'hD;
  localparam logic [3:0] DIO_IB_LAT_A = 4'h0;
  localparam logic [3:0] DIO_IB_LAT_B = 4'h1;
  localparam logic [3:0] DIO_IB_LAT_C = 4'h2;
  localparam logic [3:0] DIO_IB_PIN_A = 4'h4;
  localparam logic [3:0] DIO_IB_PIN_B = 4'h5;
  localparam logic [3:0] DIO_IB_PIN_C = 4'h6;
  localparam logic [3:0] DIO_IB_CTRL = 4'hC;
  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int DIO_CTL_W = 4;
  localparam int DIO_CTL_DBUF_EN = 0;
  localparam int DIO_CTL_POL = 1;
  localparam int DIO_CTL_MS_EN = 2;
  localparam int DIO_CTL_MASTER = 3;
  // ----------------------------------------
  // types and address helpers
  // ----------------------------------------
  typedef enum logic [1:0] {DIO_MAP_VME, DIO_MAP_ISA, DIO_MAP_NUBUS} dio_map_t;
  typedef enum logic [1:0] {DIO_SZ_BYTE, DIO_SZ_WORD, DIO_SZ_LONG} dio_size_t;

  // modulo arithmetic makes vme byte 0 land on 0x3F and come back as 0
  function automatic logic [5:0] dio_vme_to_nubus(input logic [3:0] a);
    dio_vme_to_nubus = 6'({2'b00, a} << 1) - 6'h01;
  endfunction

  function automatic logic [3:0] dio_nubus_to_vme(input logic [5:0] a);
    logic [5:0] s;
    s = a + 6'h01;
    dio_nubus_to_vme = s[4:1];
  endfunction
endpackage

// file: testbench/dio_map_props.sv
`timescale 1ns/1ps
`default_nettype none
module dio_map_props
  import dio_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic req,
  input wire logic we,
  input wire logic is_byte,
  input wire logic [DIO_AW-1:0] addr,
  input wire logic [DIO_DW-1:0] wdata,
  input wire dio_map_t map,
  input wire logic [DIO_DW-1:0] rdata,
  input wire logic ack
);
  // ----------------------------------------
  // device side of the carrier port
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // word and byte cycles; back-to-back host commands land three clocks apart
  sequence s_wrd(logic [5:0] a);
    req && !we && !is_byte && addr == a;
  endsequence
  sequence s_wwr(logic [5:0] a);
    req && we && !is_byte && addr == a;
  endsequence
  sequence s_brd(dio_map_t m);
    req && !we && is_byte && map == m;
  endsequence

  property p_ack_follows;
    ack == $past(req);
  endproperty
  property p_write_quiet;
    req && we |=> rdata == 16'h0000;
  endproperty
  property p_hi_word;
    s_wrd(6'h02) |=> rdata[15:8] == 8'h00;
  endproperty
  property p_ctrl_word;
    s_wrd(6'h0C) |=> rdata[15:4] == 12'h000;
  endproperty
  property p_unmapped;
    req && !we && !is_byte && addr[3] && addr != 6'h0C |=> rdata == 16'h0000;
  endproperty
  property p_nubus_lane;
    s_brd(DIO_MAP_NUBUS) |=> rdata[15:8] == 8'h00;
  endproperty
  property p_isa_ctrl;
    s_brd(DIO_MAP_ISA) ##0 addr == 6'h0C |=> rdata[15:4] == 12'h000;
  endproperty
  property p_vme_ctrl;
    s_brd(DIO_MAP_VME) ##0 addr == 6'h0D |=> rdata[15:4] == 12'h000;
  endproperty
  // read-back must return exactly what the previous command wrote
  property p_readback;
    s_wwr(6'h00) ##3 s_wrd(6'h00) |=> rdata == $past(wdata, 4);
  endproperty
  property p_read_clean;
    s_wrd(6'h00) ##3 s_wrd(6'h00) |=> rdata == $past(rdata, 3);
  endproperty

  a_ack_follows: assert property (p_ack_follows) else $error("ack not one clock after req");
  a_write_quiet: assert property (p_write_quiet) else $error("write answered with data");
  a_hi_word: assert property (p_hi_word) else $error("high group upper bits set");
  a_ctrl_word: assert property (p_ctrl_word) else $error("control word upper bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped word read not zero");
  a_nubus_lane: assert property (p_nubus_lane) else $error("nubus byte off low lane");
  a_isa_ctrl: assert property (p_isa_ctrl) else $error("isa control byte upper set");
  a_vme_ctrl: assert property (p_vme_ctrl) else $error("vme control byte upper set");
  a_readback: assert property (p_readback) else $error("read-back differs from write");
  a_read_clean: assert property (p_read_clean) else $error("repeated read changed");
endmodule
`default_nettype wire

// file: testbench/test_digital_io_host_address_map.sv
`timescale 1ns/1ps
`default_nettype none
module test_digital_io_host_address_map
  import dio_pkg::*;
;
  logic mclk, reset, cmd_valid, cmd_write, cmd_ready, rsp_valid, dbuf_clk;
  dio_map_t map_mode;
  dio_size_t cmd_size;
  logic [3:0] cmd_addr, sync_ctrl, ctrl_m;
  logic [31:0] cmd_wdata, rsp_rdata, rnd;
  logic [23:0] line_i, line_o, line_oe, lat_m, ext_r, old_m;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  dio_if bus_if();
  dio_host_end u_dio_host_end (.mclk(mclk), .reset(reset), .bus(bus_if), .map_mode(map_mode),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_size(cmd_size), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  dio_dev_end u_dio_dev_end (.mclk(mclk), .reset(reset), .bus(bus_if), .line_i(line_i),
    .line_o(line_o), .line_oe(line_oe), .dbuf_clk(dbuf_clk), .sync_ctrl(sync_ctrl));
  dio_map_props u_dio_map_props (.mclk(mclk), .reset(reset), .req(bus_if.req), .we(bus_if.we),
    .is_byte(bus_if.is_byte), .addr(bus_if.addr), .wdata(bus_if.wdata), .map(bus_if.map),
    .rdata(bus_if.rdata), .ack(bus_if.ack));

  // open-collector lines: pulled up unless the device or the field side sinks them
  assign line_i = (~line_oe | line_o) & ext_r;

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----------------------------------------
  // checking and reporting
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // cut a hang short; the planned run needs well under half of this
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // oldest note against each response; writes carry no data to check
  always @(posedge mclk) begin
    if (!reset && rsp_valid === 1'b1 && exp_q.size() == 0) begin
      check("note for response", 32'h0000_0001, 32'h0000_0000);
    end else if (!reset && rsp_valid === 1'b1) begin
      note = exp_q.pop_front();
      if (note[32]) check("rsp_rdata", note[31:0], rsp_rdata);
    end
  end

  // ----------------------------------------
  // reference model of latches and control
  // ----------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [15:0] wrd(input logic [3:0] a);
    logic [23:0] p;
    p = lat_m & ext_r;
    case (a)
      4'h0: return lat_m[15:0];
      4'h2: return {8'h00, lat_m[23:16]};
      4'h4: return p[15:0];
      4'h6: return {8'h00, p[23:16]};
      4'hC: return {12'h000, ctrl_m};
      default: return 16'h0000;
    endcase
  endfunction

  // byte group 0..2 for lines 1-8, 9-16, 17-24; 3 means no group
  function automatic logic [1:0] grp(input dio_map_t m, input logic [1:0] b);
    if (m == DIO_MAP_ISA) return b;
    return (b == 2'h1) ? 2'h0 : (b == 2'h0) ? 2'h1 : (b == 2'h3) ? 2'h2 : 2'h3;
  endfunction

  function automatic logic [31:0] model_rd(dio_map_t m, dio_size_t s, logic [3:0] a);
    logic [23:0] v;
    v = a[2] ? (lat_m & ext_r) : lat_m;
    if (s == DIO_SZ_LONG) return {wrd(a), wrd(a + 4'h2)};
    if (s == DIO_SZ_WORD) return {16'h0000, wrd(a)};
    if (a == ((m == DIO_MAP_ISA) ? DIO_IB_CTRL : DIO_VB_CTRL)) return {28'h000_0000, ctrl_m};
    if (a[3]) return 32'h0000_0000;
    return {24'h00_0000, 8'(v >> (8 * grp(m, a[1:0])))};
  endfunction

  task automatic wr_word(input logic [3:0] a, input logic [15:0] d);
    if (a == 4'h0) lat_m[15:0] = d;
    if (a == 4'h2) lat_m[23:16] = d[7:0];
    if (a == 4'hC) ctrl_m = d[3:0];
  endtask

  task automatic model_wr(dio_map_t m, dio_size_t s, logic [3:0] a, logic [31:0] d);
    if (s == DIO_SZ_LONG) begin
      wr_word(a, d[31:16]);
      wr_word(a + 4'h2, d[15:0]);
    end else if (s == DIO_SZ_WORD) begin
      wr_word(a, d[15:0]);
    end else if (a == ((m == DIO_MAP_ISA) ? DIO_IB_CTRL : DIO_VB_CTRL)) begin
      ctrl_m = d[3:0];
    end else if (a[3:2] == 2'h0 && grp(m, a[1:0]) != 2'h3) begin
      lat_m[8 * grp(m, a[1:0]) +: 8] = d[7:0];
    end
  endtask

  // one host command; the note is taken before the model moves on
  task automatic cmd(input logic w, input dio_size_t s, input logic [3:0] a,
    input logic [31:0] d);
    exp_q.push_back({!w, model_rd(map_mode, s, a)});
    if (w) model_wr(map_mode, s, a, d);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_size <= s;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge mclk);
    while (cmd_ready !== 1'b1) @(posedge mclk);
    cmd_valid <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic set_map(input dio_map_t m);
    map_mode <= m;
    @(posedge mclk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    dio_size_t sz;
    logic [3:0] a;
    logic [31:0] d;
    reset = 1'b1;
    {cmd_valid, cmd_write, dbuf_clk} = 3'h0;
    {cmd_addr, cmd_wdata} = 36'h0_0000_0000;
    cmd_size = DIO_SZ_WORD;
    map_mode = DIO_MAP_VME;
    {lat_m, ext_r, ctrl_m, rnd} = {24'hFF_FFFF, 24'hFF_FFFF, 4'h0, 32'h0000_003B};
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    cmd(1'b0, DIO_SZ_WORD, 4'h0, 32'h0000_0000);
    cmd(1'b0, DIO_SZ_WORD, 4'h2, 32'h0000_0000);
    cmd(1'b0, DIO_SZ_WORD, 4'hC, 32'h0000_0000);
    cmd(1'b1, DIO_SZ_WORD, 4'h0, 32'h0000_5AA5);
    cmd(1'b0, DIO_SZ_WORD, 4'h0, 32'h0000_0000);
    cmd(1'b0, DIO_SZ_WORD, 4'h0, 32'h0000_0000);
    repeat (8) @(posedge mclk);
    check("line_oe", {8'h00, ~lat_m}, {8'h00, line_oe});
    // random traffic; control writes keep double buffering and master mode off
    for (int i = 0; i < 300; i++) begin
      rnd = nxt(nxt(rnd));
      if (rnd[31:28] == 4'h0) begin
        d = nxt(rnd);
        ext_r <= rnd[23:0] | d[23:0];
        repeat (6) @(posedge mclk);
      end
      map_mode <= rnd[7] ? DIO_MAP_NUBUS : (rnd[6] ? DIO_MAP_ISA : DIO_MAP_VME);
      sz = (rnd[5] && rnd[9]) ? DIO_SZ_LONG : (rnd[4] ? DIO_SZ_WORD : DIO_SZ_BYTE);
      a = (sz == DIO_SZ_LONG) ? (rnd[3:0] & 4'hC) : rnd[3:0];
      d = nxt(rnd);
      if (a[3]) d = d & 32'hFFF2_FFF2;
      @(posedge mclk);
      cmd(rnd[8], sz, a, d);
      if (rnd[8]) repeat (8) @(posedge mclk);
    end
    // master select without mode enable, so line 23 never carries the clock
    cmd(1'b1, DIO_SZ_WORD, 4'hC, 32'h0000_FFFB);
    cmd(1'b0, DIO_SZ_WORD, 4'hC, 32'h0000_0000);
    cmd(1'b0, DIO_SZ_LONG, 4'hC, 32'h0000_0000);
    set_map(DIO_MAP_ISA);
    cmd(1'b0, DIO_SZ_BYTE, 4'hC, 32'h0000_0000);
    set_map(DIO_MAP_VME);
    cmd(1'b1, DIO_SZ_BYTE, 4'hD, 32'h0000_00F1);
    cmd(1'b0, DIO_SZ_BYTE, 4'hD, 32'h0000_0000);
    repeat (4) @(posedge mclk);
    check("sync_ctrl", {28'h000_0000, ctrl_m}, {28'h000_0000, sync_ctrl});
    // double buffered: pins move only on the selected edge of dbuf_clk
    old_m = lat_m;
    cmd(1'b1, DIO_SZ_WORD, 4'h0, {16'h0000, ~lat_m[15:0]});
    repeat (8) @(posedge mclk);
    check("line_oe held", {8'h00, ~old_m}, {8'h00, line_oe});
    dbuf_clk <= 1'b1;
    repeat (8) @(posedge mclk);
    check("line_oe rise", {8'h00, ~lat_m}, {8'h00, line_oe});
    dbuf_clk <= 1'b0;
    cmd(1'b1, DIO_SZ_WORD, 4'hC, 32'h0000_0003);
    old_m = lat_m;
    cmd(1'b1, DIO_SZ_WORD, 4'h2, {24'h00_0000, ~lat_m[23:16]});
    dbuf_clk <= 1'b1;
    repeat (8) @(posedge mclk);
    check("line_oe no rise", {8'h00, ~old_m}, {8'h00, line_oe});
    dbuf_clk <= 1'b0;
    repeat (8) @(posedge mclk);
    check("line_oe fall", {8'h00, ~lat_m}, {8'h00, line_oe});
    // second reset in mid-run restores defaults
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    {lat_m, ctrl_m} = {24'hFF_FFFF, 4'h0};
    cmd(1'b0, DIO_SZ_LONG, 4'h0, 32'h0000_0000);
    cmd(1'b0, DIO_SZ_WORD, 4'hC, 32'h0000_0000);
    repeat (8) @(posedge mclk);
    check("sync_ctrl reset", 32'h0000_0000, {28'h000_0000, sync_ctrl});
    check("line_oe reset", 32'h0000_0000, {8'h00, line_oe});
    check("line_o", 32'h0000_0000, {8'h00, line_o});
    check("pending notes", 32'h0000_0000, 32'(exp_q.size()));
    report_and_stop();
  end
endmodule
`default_nettype wire
